// ---- rtl/cisu_pkg.sv ----
package cisu_pkg;

  // ==========================================================
  // bus geometry and register byte addresses
  localparam int unsigned ADDR_W = 32;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned MB_NUM = 8;
  localparam logic [31:0] MODE_ADDR = 32'h4001_0000;
  localparam logic [31:0] IRQ_SET_ADDR = 32'h4001_0004;
  localparam logic [31:0] IRQ_CLR_ADDR = 32'h4001_0008;
  localparam logic [31:0] IRQ_MASK_ADDR = 32'h4001_000C;
  localparam logic [31:0] STATUS_ADDR = 32'h4001_0010;
  localparam logic [31:0] ERR_CNT_ADDR = 32'h4001_0020;
  localparam logic [31:0] MB_BASE_ADDR = 32'h4001_0200;
  localparam logic [31:0] MB_STRIDE = 32'h0000_0020;
  localparam logic [31:0] MB_STAT_OFS = 32'h0000_0010;

  // ==========================================================
  // mode register fields
  localparam int unsigned MODE_ENABLE_BIT = 0;
  localparam int unsigned MODE_LPM_BIT = 1;
  localparam int unsigned MODE_NO_RETRY_BIT = 7;
  localparam logic [7:0] MODE_RESET = 8'h00;

  // ==========================================================
  // shared layout of enable, disable, mask and status
  localparam int unsigned ST_MB_LSB = 0;
  localparam int unsigned ST_ERR_ACTIVE = 16;
  localparam int unsigned ST_WARNING = 17;
  localparam int unsigned ST_ERR_PASSIVE = 18;
  localparam int unsigned ST_BUS_OFF = 19;
  localparam int unsigned ST_SLEEP = 20;
  localparam int unsigned ST_WAKEUP = 21;
  localparam int unsigned ST_TIMER_OVF = 22;
  localparam int unsigned ST_TIMESTAMP = 23;
  localparam int unsigned ST_PROTO_LSB = 24;
  localparam int unsigned ST_RX_BUSY = 29;
  localparam int unsigned ST_TX_BUSY = 30;
  localparam int unsigned ST_OVL_BUSY = 31;
  localparam logic [31:0] IRQ_VALID_BITS = 32'h1FFF_00FF;
  localparam logic [31:0] MASK_RESET = 32'h0000_0000;

  // ==========================================================
  // mailbox status fields and error thresholds
  localparam int unsigned MB_READY_BIT = 23;
  localparam int unsigned MB_ABORT_BIT = 22;
  localparam int unsigned MB_PENDING_BIT = 0;
  localparam logic [8:0] WARN_LIMIT = 9'h060;
  localparam logic [8:0] PASSIVE_LIMIT = 9'h080;
  localparam logic [8:0] BUS_OFF_LIMIT = 9'h100;
  localparam int unsigned ECR_TEC_LSB = 16;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic [MB_NUM-1:0] tx_req;
    logic [MB_NUM-1:0] tx_ok;
    logic [MB_NUM-1:0] arb_lost;
  } cisu_mb_evt_t;

  typedef struct packed {
    logic bit_err;
    logic form_err;
    logic ack_err;
    logic stuff_err;
    logic crc_err;
  } cisu_proto_err_t;

  typedef struct packed {
    logic ovl_busy;
    logic tx_busy;
    logic rx_busy;
  } cisu_busy_t;

  typedef enum logic [2:0] {
    PW_ACTIVE = 3'b001,
    PW_SLEEP = 3'b010,
    PW_RESYNC = 3'b100
  } cisu_pw_t;

endpackage

// ---- rtl/cisu_irq_status.sv ----
// Summary of operation
// - arbitration loss keeps request pending by default
// - no-retry setting aborts request, raises abort, ready
// - enable-set writes of one set mask bits
// - common bit layout for all four registers
// - enable-clear writes of one clear mask bits
// - mask view returns accumulated enabled sources
// - mailbox event bit is ready or abort
// - error active when neither passive nor off
// - warning at either counter ninety-six or more
// - error passive at either counter 128+
// - bus off when transmit counter 256+
// - error state flags sticky, cleared by read
// - sleep flag follows low-power mode
// - wakeup flag follows not-low-power mode
// - wakeup resynchronises before traffic resumes
// - event and protocol flags clear on read
// - receiver busy follows reception activity
//
// Design decision made here: the Wishbone interface to the registers.
module cisu_irq_status #(
  parameter int unsigned MB_N = cisu_pkg::MB_NUM
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [cisu_pkg::ADDR_W-1:0] wb_adr_i,
  input wire logic [cisu_pkg::DATA_W-1:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [cisu_pkg::DATA_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  // protocol engine side, same clock
  input wire cisu_pkg::cisu_mb_evt_t mb_evt_i,
  input wire cisu_pkg::cisu_proto_err_t proto_err_i,
  input wire cisu_pkg::cisu_busy_t busy_i,
  input wire logic [8:0] transmit_error_count_i,
  input wire logic [7:0] receive_error_count_i,
  input wire logic timer_ovf_i,
  input wire logic timestamp_i,
  input wire logic bus_idle_i,
  input wire logic tx_idle_i,
  // bus receive pin, asynchronous
  input wire logic can_rx_i,
  // outputs
  output logic [MB_N-1:0] tx_pending_o,
  output logic comm_enable_o,
  output logic irq_o
);

  // ==========================================================
  // bus decode
  logic bus_req;
  logic wr_stb;
  logic rd_stb;
  logic [31:0] wdata_be;
  logic ack_r;
  logic [31:0] rdata_r;

  // a request is taken at the first edge; a write lands at the edge that shows ack,
  // so a classic master sees its effect exactly where it samples the answer
  assign bus_req = ce_i & wb_cyc_i & wb_stb_i & ~ack_r;
  assign wr_stb = ce_i & wb_cyc_i & wb_stb_i & wb_we_i & ack_r;
  assign rd_stb = bus_req & ~wb_we_i;

  // byte enables gate the written ones
  always_comb begin
    wdata_be = '0;
    for (int b = 0; b < 4; b++) begin
      if (wb_sel_i[b]) begin
        wdata_be[b*8 +: 8] = wb_dat_i[b*8 +: 8];
      end
    end
  end

  logic hit_mode;
  logic hit_set;
  logic hit_clr;
  logic hit_status;
  assign hit_mode = (wb_adr_i == cisu_pkg::MODE_ADDR);
  assign hit_set = (wb_adr_i == cisu_pkg::IRQ_SET_ADDR);
  assign hit_clr = (wb_adr_i == cisu_pkg::IRQ_CLR_ADDR);
  assign hit_status = (wb_adr_i == cisu_pkg::STATUS_ADDR);

  // ==========================================================
  // mode register
  logic [7:0] mode_r;
  logic lpm_clear;
  logic no_retry_on_loss;
  assign no_retry_on_loss = mode_r[cisu_pkg::MODE_NO_RETRY_BIT];

  // software write; a wakeup drops the low-power request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_r <= cisu_pkg::MODE_RESET;
    end else if (ce_i) begin
      if (wr_stb && hit_mode) begin
        mode_r <= wdata_be[7:0];
      end else if (lpm_clear) begin
        mode_r[cisu_pkg::MODE_LPM_BIT] <= 1'b0;
      end
    end
  end

  // ==========================================================
  // interrupt mask
  logic [31:0] mask_r;

  // set and clear sit at separate addresses, so one write never does both;
  // bits outside the shared layout never stick
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mask_r <= cisu_pkg::MASK_RESET;
    end else if (ce_i) begin
      if (wr_stb && hit_clr) begin
        mask_r <= mask_r & ~(wdata_be & cisu_pkg::IRQ_VALID_BITS);
      end else if (wr_stb && hit_set) begin
        mask_r <= mask_r | (wdata_be & cisu_pkg::IRQ_VALID_BITS);
      end
    end
  end

  // ==========================================================
  // mailbox transfer state
  logic [MB_N-1:0] pend_r;
  logic [MB_N-1:0] ready_r;
  logic [MB_N-1:0] abort_r;

  genvar m;
  generate
    for (m = 0; m < MB_N; m++) begin : g_mb
      // pending request, cleared by success or a no-retry loss
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          pend_r[m] <= 1'b0;
        end else if (ce_i) begin
          if (mb_evt_i.tx_req[m]) begin
            pend_r[m] <= 1'b1;
          end else if (mb_evt_i.tx_ok[m]) begin
            pend_r[m] <= 1'b0;
          end else if (mb_evt_i.arb_lost[m]) begin
            pend_r[m] <= ~no_retry_on_loss & pend_r[m];
          end
        end
      end

      // ready and abort flags; a new request clears them and outranks
      // the outcome of the one before, as the pending flag does
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          ready_r[m] <= 1'b0;
          abort_r[m] <= 1'b0;
        end else if (ce_i) begin
          if (mb_evt_i.tx_req[m]) begin
            ready_r[m] <= 1'b0;
            abort_r[m] <= 1'b0;
          end else if (mb_evt_i.tx_ok[m]) begin
            ready_r[m] <= 1'b1;
          end else if (mb_evt_i.arb_lost[m] && no_retry_on_loss && pend_r[m]) begin
            ready_r[m] <= 1'b1;
            abort_r[m] <= 1'b1;
          end
        end
      end
    end
  endgenerate

  // ==========================================================
  // receive pin synchroniser, three stages
  // reset fills the chain with the recessive level, so no false wake follows reset
  logic [2:0] rx_sync_r;
  logic rx_dominant;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_sync_r <= 3'h7;
    end else if (ce_i) begin
      rx_sync_r <= {rx_sync_r[1:0], can_rx_i};
    end
  end

  // the first stage may be metastable; only the second stage reads it
  // second and third stage agree on a dominant level
  assign rx_dominant = ~rx_sync_r[1] & ~rx_sync_r[2];

  // ==========================================================
  // low-power state machine
  cisu_pkg::cisu_pw_t pw_r;
  cisu_pkg::cisu_pw_t pw_nxt;
  logic lpm_req;
  assign lpm_req = mode_r[cisu_pkg::MODE_LPM_BIT];

  // sleep after pending work, wake on request drop or bus activity
  // a dominant level while asleep is the wake event; resync waits for an idle bus
  always_comb begin
    pw_nxt = pw_r;
    lpm_clear = 1'b0;
    case (pw_r)
      cisu_pkg::PW_ACTIVE: begin
        if (lpm_req && ~|pend_r && tx_idle_i) begin
          pw_nxt = cisu_pkg::PW_SLEEP;
        end
      end
      cisu_pkg::PW_SLEEP: begin
        if (rx_dominant) begin
          lpm_clear = 1'b1;
          pw_nxt = cisu_pkg::PW_RESYNC;
        end else if (!lpm_req) begin
          pw_nxt = cisu_pkg::PW_RESYNC;
        end
      end
      cisu_pkg::PW_RESYNC: begin
        if (bus_idle_i) begin
          pw_nxt = cisu_pkg::PW_ACTIVE;
        end
      end
      default: begin
        pw_nxt = cisu_pkg::PW_ACTIVE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pw_r <= cisu_pkg::PW_ACTIVE;
    end else if (ce_i) begin
      pw_r <= pw_nxt;
    end
  end

  // ==========================================================
  // error state derived from the counters
  // bus off implies passive, so error active drops in both
  logic st_passive;
  logic st_bus_off;
  logic st_warning;
  logic st_active;
  assign st_bus_off = (transmit_error_count_i >= cisu_pkg::BUS_OFF_LIMIT);
  assign st_passive = (transmit_error_count_i >= cisu_pkg::PASSIVE_LIMIT) |
                      ({1'b0, receive_error_count_i} >= cisu_pkg::PASSIVE_LIMIT);
  assign st_warning = (transmit_error_count_i >= cisu_pkg::WARN_LIMIT) |
                      ({1'b0, receive_error_count_i} >= cisu_pkg::WARN_LIMIT);
  assign st_active = ~st_passive & ~st_bus_off;

  // ==========================================================
  // sticky flags, bits 16..19 and 22..28
  logic [31:0] sticky_set;
  logic [31:0] sticky_clr;
  logic [31:0] sticky_r;

  always_comb begin
    sticky_set = '0;
    sticky_set[cisu_pkg::ST_ERR_ACTIVE] = st_active;
    sticky_set[cisu_pkg::ST_WARNING] = st_warning;
    sticky_set[cisu_pkg::ST_ERR_PASSIVE] = st_passive;
    sticky_set[cisu_pkg::ST_BUS_OFF] = st_bus_off;
    sticky_set[cisu_pkg::ST_TIMER_OVF] = timer_ovf_i;
    sticky_set[cisu_pkg::ST_TIMESTAMP] = timestamp_i;
    sticky_set[cisu_pkg::ST_PROTO_LSB +: 5] = proto_err_i;
  end

  // a status read clears all; a written one clears that bit
  always_comb begin
    sticky_clr = '0;
    if (rd_stb && hit_status) begin
      sticky_clr = '1;
    end else if (wr_stb && hit_status) begin
      sticky_clr = wdata_be;
    end
  end

  // a set in the clearing cycle survives
  // read data is captured from the old value at the clearing edge,
  // so no event falls between sampling and clearing
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sticky_r <= '0;
    end else if (ce_i) begin
      sticky_r <= (sticky_r & ~sticky_clr) | sticky_set;
    end
  end

  // ==========================================================
  // status word
  logic [31:0] status;

  always_comb begin
    status = '0;
    status[cisu_pkg::ST_MB_LSB +: 8] = 8'h00;
    status[cisu_pkg::ST_MB_LSB +: MB_N] = ready_r | abort_r;
    status[cisu_pkg::ST_ERR_ACTIVE] = sticky_r[cisu_pkg::ST_ERR_ACTIVE];
    status[cisu_pkg::ST_WARNING] = sticky_r[cisu_pkg::ST_WARNING];
    status[cisu_pkg::ST_ERR_PASSIVE] = sticky_r[cisu_pkg::ST_ERR_PASSIVE];
    status[cisu_pkg::ST_BUS_OFF] = sticky_r[cisu_pkg::ST_BUS_OFF];
    status[cisu_pkg::ST_SLEEP] = (pw_r == cisu_pkg::PW_SLEEP);
    status[cisu_pkg::ST_WAKEUP] = (pw_r != cisu_pkg::PW_SLEEP);
    status[cisu_pkg::ST_TIMER_OVF] = sticky_r[cisu_pkg::ST_TIMER_OVF];
    status[cisu_pkg::ST_TIMESTAMP] = sticky_r[cisu_pkg::ST_TIMESTAMP];
    status[cisu_pkg::ST_PROTO_LSB +: 5] = sticky_r[cisu_pkg::ST_PROTO_LSB +: 5];
    status[cisu_pkg::ST_RX_BUSY] = busy_i.rx_busy;
    status[cisu_pkg::ST_TX_BUSY] = busy_i.tx_busy;
    status[cisu_pkg::ST_OVL_BUSY] = busy_i.ovl_busy;
  end

  // ==========================================================
  // read multiplexer, including per-mailbox status words
  logic [31:0] rd_mux;
  logic [31:0] mb_ofs;

  always_comb begin
    rd_mux = '0;
    mb_ofs = wb_adr_i - cisu_pkg::MB_BASE_ADDR;
    if (hit_mode) begin
      rd_mux[7:0] = mode_r;
    end else if (wb_adr_i == cisu_pkg::IRQ_MASK_ADDR) begin
      rd_mux = mask_r;
    end else if (hit_status) begin
      rd_mux = status;
    end else if (wb_adr_i == cisu_pkg::ERR_CNT_ADDR) begin
      rd_mux[7:0] = receive_error_count_i;
      rd_mux[cisu_pkg::ECR_TEC_LSB +: 9] = transmit_error_count_i;
    end else begin
      for (int k = 0; k < MB_N; k++) begin
        if (mb_ofs == (32'(k) * cisu_pkg::MB_STRIDE + cisu_pkg::MB_STAT_OFS)) begin
          rd_mux[cisu_pkg::MB_READY_BIT] = ready_r[k];
          rd_mux[cisu_pkg::MB_ABORT_BIT] = abort_r[k];
          rd_mux[cisu_pkg::MB_PENDING_BIT] = pend_r[k];
        end
      end
    end
  end

  // one-cycle ack; unmapped reads return zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      rdata_r <= '0;
    end else if (ce_i) begin
      ack_r <= bus_req;
      if (rd_stb) begin
        rdata_r <= rd_mux;
      end
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdata_r;

  // ==========================================================
  // registered outputs
  // live bits such as sleep or wakeup raise the line while they stand unmasked; the busy bits can never raise it
  logic irq_r;
  logic comm_en_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_r <= 1'b0;
      comm_en_r <= 1'b0;
    end else if (ce_i) begin
      irq_r <= |(status & mask_r & cisu_pkg::IRQ_VALID_BITS);
      comm_en_r <= mode_r[cisu_pkg::MODE_ENABLE_BIT] & (pw_r == cisu_pkg::PW_ACTIVE);
    end
  end

  assign irq_o = irq_r;
  assign comm_enable_o = comm_en_r;
  assign tx_pending_o = pend_r;

endmodule

// ---- tb/cisu_irq_status_chk.sv ----
// ====
// checker: bus answers, error flags, retry and interrupt
module cisu_irq_status_chk #(
  parameter int unsigned MB_N = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire cisu_pkg::cisu_mb_evt_t mb_evt_i,
  input wire logic [8:0] transmit_error_count_i,
  input wire logic [7:0] receive_error_count_i,
  input wire logic [MB_N-1:0] tx_pending_o,
  input wire logic irq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic [31:0] mask_r;
  logic [31:0] wd;
  logic noretry_r;
  logic wr;
  logic st;
  logic quiet;
  logic [8:0] transmit_error_count;
  logic [7:0] receive_error_count;
  logic [7:0] lost;
  // writes land at the ack edge; status read answers
  assign wr = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
  assign wd = wb_dat_i & {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                          {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign st = wb_ack_o & ~wb_we_i & (wb_adr_i == cisu_pkg::STATUS_ADDR);
  assign quiet = ~|mb_evt_i.tx_req & ~|mb_evt_i.tx_ok;
  assign transmit_error_count = transmit_error_count_i;
  assign receive_error_count = receive_error_count_i;
  assign lost = mb_evt_i.arb_lost;
  // shadow of the mask from set and clear writes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mask_r <= 32'h0;
    end else if (wr && wb_adr_i == cisu_pkg::IRQ_SET_ADDR) begin
      mask_r <= (mask_r | wd) & cisu_pkg::IRQ_VALID_BITS;
    end else if (wr && wb_adr_i == cisu_pkg::IRQ_CLR_ADDR) begin
      mask_r <= mask_r & ~wd;
    end
  end
  // shadow of the no-retry setting
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      noretry_r <= 1'b0;
    end else if (wr && wb_adr_i == cisu_pkg::MODE_ADDR && wb_sel_i[0]) begin
      noretry_r <= wb_dat_i[7];
    end
  end
  property p_kept;
    !noretry_r && quiet && lost != 8'h00 |=> tx_pending_o == $past(tx_pending_o);
  endproperty
  a_kept: assert property (p_kept) else $error("request lost on arbitration");
  property p_abort;
    noretry_r && quiet |=> tx_pending_o == ($past(tx_pending_o) & ~$past(lost));
  endproperty
  a_abort: assert property (p_abort) else $error("request not aborted");
  property p_view;
    wb_ack_o && !wb_we_i && wb_adr_i == cisu_pkg::IRQ_MASK_ADDR |-> wb_dat_o == mask_r;
  endproperty
  a_view: assert property (p_view) else $error("mask view wrong");
  property p_active;
    st && !$past(rst_i, 2) && $past(transmit_error_count, 2) < 9'h080 && $past(receive_error_count, 2) < 8'h80 |-> wb_dat_o[16];
  endproperty
  a_active: assert property (p_active) else $error("error active missing");
  property p_warn;
    st && ($past(transmit_error_count, 2) >= 9'h060 || $past(receive_error_count, 2) >= 8'h60) |-> wb_dat_o[17];
  endproperty
  a_warn: assert property (p_warn) else $error("warning missing");
  property p_passive;
    st && ($past(transmit_error_count, 2) >= 9'h080 || $past(receive_error_count, 2) >= 8'h80) |-> wb_dat_o[18];
  endproperty
  a_passive: assert property (p_passive) else $error("passive missing");
  property p_off;
    st && $past(transmit_error_count, 2) >= 9'h100 |-> wb_dat_o[19];
  endproperty
  a_off: assert property (p_off) else $error("bus off missing");
  property p_pair;
    st |-> wb_dat_o[20] != wb_dat_o[21];
  endproperty
  a_pair: assert property (p_pair) else $error("sleep and wakeup agree");
  property p_quiet;
    mask_r == 32'h0 ##1 mask_r == 32'h0 |-> !irq_o;
  endproperty
  a_quiet: assert property (p_quiet) else $error("interrupt while masked");
  c_off: cover property (st && wb_dat_o[19]);
  c_irq: cover property (irq_o);
  c_abort: cover property (noretry_r && lost != 8'h00 && tx_pending_o != 8'h00);
endmodule
bind cisu_irq_status cisu_irq_status_chk #(.MB_N(MB_N)) chk_u (
  .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_sel_i,
  .wb_dat_o, .wb_ack_o, .mb_evt_i, .transmit_error_count_i, .receive_error_count_i,
  .tx_pending_o, .irq_o);

// ---- tb/cisu_bus_node.sv ----
// ====
// far side: a node that wakes the controller with a frame
module cisu_bus_node #(
  parameter int IDLE_GAP = 11
) (
  input wire logic clk_i,
  input wire logic wake_i,
  input wire logic [3:0] lag_i,
  output logic can_rx_o,
  output logic bus_idle_o,
  output logic tx_idle_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;
  // dominant burst of 4+lag cycles, then a recessive gap
  always @(posedge clk_i) begin
    if (wake_i) begin
      cnt <= 4 + lag_i + IDLE_GAP;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
    end
  end
  // recessive outside the burst, idle only after the gap
  assign can_rx_o = !(cnt > IDLE_GAP);
  assign bus_idle_o = (cnt == 0);
  assign tx_idle_o = (cnt == 0);
endmodule

// ---- tb/can_irq_status_unit_bench.sv ----
`define CHK(nm, e, g) begin \
  n_tests++; \
  if ((g) !== (e)) begin \
    mismatches++; \
    $display("[FAIL] %s expected %0h seen %0h", nm, e, g); \
  end \
end
// ====
// bench: registers, error flags, mailboxes, low power
module can_irq_status_unit_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic ce_i = 1'b1; // clock kept running for wakeups
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [31:0] adr = 32'h0;
  logic [31:0] wdat = 32'h0;
  cisu_pkg::cisu_mb_evt_t evt = '0;
  cisu_pkg::cisu_proto_err_t perr = '0;
  cisu_pkg::cisu_busy_t busy = '0;
  logic [8:0] transmit_error_count = 9'h000;
  logic [7:0] receive_error_count = 8'h00;
  logic timer_overflow_flag = 1'b0;
  logic timestamp_flag = 1'b0;
  logic wake = 1'b0;
  logic [3:0] lag = 4'h0;
  logic ack, rx, bidle, tidle, cen, irq;
  logic [7:0] pend, pv, a;
  logic [31:0] dat_o, rdat, m, v;
  logic [16:0] tr;
  logic [16:0] tbl [9] = '{17'h00000, 17'h06000, 17'h00060, 17'h05F5F, 17'h08000,
                           17'h00080, 17'h10000, 17'h07F7F, 17'h1FFFF};
  int mismatches = 0;
  int n_tests = 0;
  int k;
  cisu_irq_status dut_u (
    .clk_i, .rst_i, .ce_i, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_dat_i(wdat), .wb_sel_i(4'hF), .wb_dat_o(dat_o), .wb_ack_o(ack), .mb_evt_i(evt),
    .proto_err_i(perr), .busy_i(busy), .transmit_error_count_i(transmit_error_count),
    .receive_error_count_i(receive_error_count), .timer_ovf_i(timer_overflow_flag), .timestamp_i(timestamp_flag),
    .bus_idle_i(bidle), .tx_idle_i(tidle), .can_rx_i(rx), .tx_pending_o(pend),
    .comm_enable_o(cen), .irq_o(irq));
  cisu_bus_node node_u (.clk_i, .wake_i(wake), .lag_i(lag), .can_rx_o(rx),
    .bus_idle_o(bidle), .tx_idle_o(tidle));
  // clock
  initial begin
    forever #2 clk_i = ~clk_i;
  end
  // one wishbone classic cycle, held until ack
  task automatic bus(input logic w, input logic [31:0] ad, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= ad;
    wdat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    rdat = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 20) begin
      mismatches++;
      give_verdict();
    end
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [31:0] ad);
    bus(1'b0, ad, 32'h0);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic pulse(input cisu_pkg::cisu_mb_evt_t e);
    evt <= e;
    @(posedge clk_i);
    evt <= '0;
    @(posedge clk_i);
  endtask
  // expected {bus off, passive, warning, active} for {tec, rec}
  function automatic logic [3:0] err_exp(input logic [16:0] t);
    logic p;
    p = t[16:8] >= 9'h080 || t[7:0] >= 8'h80;
    return {t[16:8] >= 9'h100, p, t[16:8] >= 9'h060 || t[7:0] >= 8'h60, !p};
  endfunction
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    v = $urandom(5927);
    tick(8);
    rst_i <= 1'b0;
    tick(1);
    `CHK("irq", 1'b0, irq)
    rd(cisu_pkg::IRQ_MASK_ADDR);
    `CHK("mask", 32'h0, rdat)
    m = 32'h0;
    for (int i = 0; i < 8; i++) begin
      v = $urandom;
      bus(1'b1, cisu_pkg::IRQ_SET_ADDR, v);
      m = (m | v) & cisu_pkg::IRQ_VALID_BITS;
      v = $urandom & $urandom;
      bus(1'b1, cisu_pkg::IRQ_CLR_ADDR, v);
      m = m & ~v;
      rd(cisu_pkg::IRQ_MASK_ADDR);
      `CHK("mask", m, rdat)
    end
    bus(1'b1, cisu_pkg::IRQ_MASK_ADDR, 32'hFFFF_FFFF);
    bus(1'b1, 32'h4001_0030, 32'hFFFF_FFFF);
    rd(cisu_pkg::IRQ_MASK_ADDR);
    `CHK("mask ro", m, rdat)
    rd(32'h4001_0030);
    `CHK("unmapped", 32'h0, rdat)
    $display("test mask done");
    for (int i = 0; i < 12; i++) begin
      tr = (i < 9) ? tbl[i] : 17'($urandom);
      transmit_error_count <= tr[16:8];
      receive_error_count <= tr[7:0];
      tick(3);
      rd(cisu_pkg::STATUS_ADDR);
      rd(cisu_pkg::STATUS_ADDR);
      `CHK("errstate", err_exp(tr), rdat[19:16])
    end
    transmit_error_count <= 9'h100;
    tick(3);
    transmit_error_count <= 9'h000;
    receive_error_count <= 8'h00;
    tick(3);
    rd(cisu_pkg::STATUS_ADDR);
    `CHK("sticky", 4'hF, rdat[19:16])
    rd(cisu_pkg::STATUS_ADDR);
    `CHK("cleared", 4'h1, rdat[19:16])
    $display("test error state done");
    v = $urandom;
    perr <= v[4:0];
    timer_overflow_flag <= 1'b1;
    timestamp_flag <= 1'b1;
    busy <= 3'b001;
    tick(1);
    perr <= '0;
    timer_overflow_flag <= 1'b0;
    timestamp_flag <= 1'b0;
    tick(2);
    rd(cisu_pkg::STATUS_ADDR);
    `CHK("events", {1'b1, v[4:0], 2'b11}, rdat[29:22])
    busy <= 3'b000;
    tick(2);
    rd(cisu_pkg::STATUS_ADDR);
    `CHK("events gone", 8'h00, rdat[29:22])
    timer_overflow_flag <= 1'b1;
    timestamp_flag <= 1'b1;
    tick(1);
    timer_overflow_flag <= 1'b0;
    timestamp_flag <= 1'b0;
    bus(1'b1, cisu_pkg::STATUS_ADDR, 32'h0080_0000);
    rd(cisu_pkg::STATUS_ADDR);
    `CHK("one clears one", 2'b01, rdat[23:22])
    $display("test events done");
    bus(1'b1, cisu_pkg::IRQ_CLR_ADDR, 32'hFFFF_FFFF);
    bus(1'b1, cisu_pkg::MODE_ADDR, 32'h0000_0001);
    v = $urandom;
    pv = v[7:0] | 8'h01;
    a = v[15:8] | 8'h01;
    pulse({pv, 8'h00, 8'h00});
    pulse({8'h00, 8'h00, 8'hFF});
    `CHK("kept", pv, pend)
    rd(cisu_pkg::STATUS_ADDR);
    `CHK("no event", 8'h00, rdat[7:0])
    bus(1'b1, cisu_pkg::MODE_ADDR, 32'h0000_0081);
    pulse({8'h00, 8'h00, a});
    `CHK("aborted", pv & ~a, pend)
    rd(cisu_pkg::STATUS_ADDR);
    `CHK("abort event", pv & a, rdat[7:0])
    rd(cisu_pkg::MB_BASE_ADDR + cisu_pkg::MB_STAT_OFS);
    `CHK("mailbox 0 flags", 32'h00C0_0000, rdat)
    bus(1'b1, cisu_pkg::IRQ_SET_ADDR, 32'h0000_00FF);
    tick(2);
    `CHK("irq on", 1'b1, irq)
    pulse({8'h00, pv, 8'h00});
    `CHK("sent", 8'h00, pend)
    rd(cisu_pkg::STATUS_ADDR);
    `CHK("ready event", pv, rdat[7:0])
    bus(1'b1, cisu_pkg::IRQ_CLR_ADDR, 32'h0000_00FF);
    tick(2);
    `CHK("irq off", 1'b0, irq)
    ce_i <= 1'b0;
    pulse({8'hFF, 8'h00, 8'h00});
    ce_i <= 1'b1;
    `CHK("frozen", 8'h00, pend)
    $display("test mailbox done");
    `CHK("enabled", 1'b1, cen)
    bus(1'b1, cisu_pkg::MODE_ADDR, 32'h0000_0003);
    tick(4);
    rd(cisu_pkg::STATUS_ADDR);
    `CHK("asleep", 2'b01, rdat[21:20])
    `CHK("halted", 1'b0, cen)
    lag <= v[19:16];
    wake <= 1'b1;
    tick(1);
    wake <= 1'b0;
    tick(6);
    `CHK("resync", 1'b0, cen)
    k = 0;
    while (cen !== 1'b1 && k < 80) begin
      tick(1);
      k++;
    end
    `CHK("woken", 1'b1, cen)
    rd(cisu_pkg::STATUS_ADDR);
    `CHK("awake", 2'b10, rdat[21:20])
    $display("test low power done");
    give_verdict();
  end
endmodule
